// file: rtl/maic_consts.svh
// Constants for the multi-axis interpolation controller.
// Assumes inclusion by bare name from rtl files; definitions only.
`ifndef MAIC_CONSTS_SVH
`define MAIC_CONSTS_SVH
`define MAIC_MODE_LIN1_CONT  8'h60
`define MAIC_MODE_LIN1_INC   8'h61
`define MAIC_MODE_LIN2_CONT  8'h62
`define MAIC_MODE_LIN2_INC   8'h63
`define MAIC_MODE_CIRC_CW    8'h64
`define MAIC_MODE_CIRC_CCW   8'h65
`define MAIC_RATE_DIV_RESET  16'h0001
`define MAIC_STS_BUSY_BIT    0
`define MAIC_STS_DONE_BIT    1
`define MAIC_STS_ABORT_BIT   2
`define MAIC_STS_DECEL_BIT   3
`define MAIC_STS_CIRC_BIT    4
`endif

// file: rtl/maic_pkg.sv
// Types shared by the interpolation controller files.
// Assumes nothing beyond a SystemVerilog compiler.
package maic_pkg;
    typedef enum logic [1:0] {
        MAIC_IDLE,
        MAIC_CHECK,
        MAIC_RUN,
        MAIC_DONE
    } maic_state_t;
endpackage

// file: rtl/maic_follow.sv
// One following-axis pulse distributor (accumulator per axis).
// Assumes main-axis pulses arrive as one-cycle strobes on the same clock.
`timescale 1ns/1ps
module maic_follow
    import maic_pkg::*;
#(
    parameter int W = 28
) (
    input  wire logic         core_clk,   // System clock
    input  wire logic         nrst,       // Sync reset, active low
    input  wire logic         load,       // Preset accumulator to half main amount at start
    input  wire logic         main_step,  // Main axis pulse strobe
    input  wire logic [W-1:0] own_abs,    // This axis absolute amount
    input  wire logic [W-1:0] main_abs,   // Main axis absolute amount
    output logic              step        // Pulse for this axis
);
    logic [W:0] acc;
    logic [W:0] next_acc;
    logic       next_step;

    // Add own amount per main pulse, emit once it reaches main amount
    always_comb begin
        next_acc  = acc;
        next_step = 1'b0;
        if (load) begin
            next_acc = {1'b0, main_abs >> 1};  // Half offset keeps error within half a unit
        end else if (main_step) begin
            next_acc = acc + {1'b0, own_abs};
            if (next_acc >= {1'b0, main_abs}) begin
                next_acc  = next_acc - {1'b0, main_abs};
                next_step = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            acc  <= '0;
            step <= 1'b0;
        end else begin
            acc  <= next_acc;
            step <= next_step;
        end
    end
endmodule

// file: rtl/maic_core.sv
// Multi-axis linear interpolation and circular setup controller.
// Assumes per-axis settings are held stable by software while busy, and that
// the start and stop lines of cascaded chips share this clock source.
`timescale 1ns/1ps
`include "maic_consts.svh"

// Notes on behaviour
// - Pulse direction follows move amount sign
// - Single-axis incremental linear sets abort, no pulses
// - Largest absolute move amount is main axis
// - Following pulses distributed from main pulses
// - Stop at main remaining zero, then complete
// - All-zero move amounts complete immediately, except in multi-chip continuous
// - Decelerate below slowdown point in stated modes
// - Single-chip speed from control axis only
// - Multi-chip mode runs constant rate only
// - Command with axis selects acts on all
// - One shared interpolation status for all
// - Chips start and stop on shared lines
// - Multi-chip continuous runs until stop command
// - Zero reference in multi-chip incremental aborts
// - Remote main axis in multi-chip incremental: each axis stops alone
// - Circular pair control axis is earliest
// - Circular mode only sets up the pair, with no pulses or deceleration
// - Trajectory stays within half a unit
// - Start abort reported as error cause
module maic_core
    import maic_pkg::*;
#(
    parameter int N = 4,   // Number of axes
    parameter int W = 28   // Move amount width
) (
    input  wire logic                 core_clk,          // System clock
    input  wire logic                 nrst,              // Sync reset, active low
    input  wire logic [7:0]           operation_mode_field [N], // Mode per axis
    input  wire logic [W-1:0]         target_move_amount [N],   // Signed amount per axis
    input  wire logic [W-1:0]         interpolation_reference_amount [N], // Reference
    input  wire logic [W-1:0]         slowdown_point_value,     // Slowdown point
    input  wire logic [N-1:0]         slowdown_point_manual_select, // Per axis
    input  wire logic [N-1:0]         high_speed_correction_manual_select, // Per axis
    input  wire logic [15:0]          high_speed_value [N],     // Rate divider per axis
    input  wire logic                 remote_main,       // Main axis on another chip
    input  wire logic                 command_write_area, // Command strobe
    input  wire logic                 command_is_stop,   // 1 stop, 0 start
    input  wire logic [N-1:0]         axis_select_bits,  // Axes named by command
    input  wire logic                 simultaneous_start_line, // Pin, active high
    input  wire logic                 simultaneous_stop_line,  // Pin, active high
    output logic [N-1:0]              pulse_out,         // Command pulse strobes
    output logic [N-1:0]              dir_neg,           // 1 = negative direction
    output logic [N-1:0]              busy,              // Axis busy
    output logic [N-1:0]              decel,             // Deceleration request
    output logic                      start_abort_error_flag, // Sticky error cause
    output logic                      circ_setup_ok,     // Circular pair accepted
    output logic [N-1:0]              circ_ctrl_axis,    // Circular control axis
    output logic [7:0]                shared_interpolation_status, // Shared status
    output logic [1:0]                ctrl_axis          // Speed source axis
);
    maic_state_t    state, next_state;
    logic [N-1:0]   sel, next_sel;
    logic [7:0]     mode, next_mode;
    logic [1:0]     main_ax, next_main_ax;
    logic [1:0]     cax, next_cax;
    logic [W-1:0]   mag [N];
    logic [W-1:0]   rem [N], next_rem [N];
    logic [W-1:0]   main_abs;
    logic [15:0]    rate_cnt, next_rate_cnt;
    logic           main_tick, next_main_tick;
    logic [N-1:0]   fstep;
    logic [N-1:0]   next_pulse, next_dir, next_busy, next_decel;
    logic           next_abort;
    logic           next_cok;
    logic [N-1:0]   next_cax1h;
    logic [7:0]     next_sts;
    logic [2:0]     sta_sync, stp_sync;
    logic           cstart, cstop;
    logic           cmd_start, cmd_stop;
    logic           do_start, do_stop;

    // Start and stop pins pass three flops; a level counts once flops two and three agree
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            sta_sync <= 3'h0;
            stp_sync <= 3'h0;
        end else begin
            sta_sync <= {sta_sync[1:0], simultaneous_start_line};
            stp_sync <= {stp_sync[1:0], simultaneous_stop_line};
        end
    end
    assign cstart = sta_sync[1] & sta_sync[2];
    assign cstop  = stp_sync[1] & stp_sync[2];

    // One command names every axis; pins act like a command on the held selection
    assign cmd_start = command_write_area & ~command_is_stop & (|axis_select_bits);
    assign cmd_stop  = command_write_area & command_is_stop;
    assign do_start  = cmd_start | cstart;
    assign do_stop   = cmd_stop | cstop;

    // Absolute move amounts of every axis
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_ax
            assign mag[g] = target_move_amount[g][W-1] ? (~target_move_amount[g] + 1'b1)
                                                       : target_move_amount[g];
            maic_follow #(.W(W)) u_follow (
                .core_clk  (core_clk),
                .nrst      (nrst),
                .load      (state == MAIC_CHECK),
                .main_step (next_main_tick),  // Early tick: step lands with main pulse
                .own_abs   (mag[g]),
                .main_abs  (main_abs),
                .step      (fstep[g])
            );
        end
    endgenerate
    assign main_abs = mag[next_main_ax];  // New main already known while loading

    // Sequencer: check, run, complete; all axes share one state
    always_comb begin
        int   cnt;
        logic allzero;
        logic ripzero;
        logic [W-1:0] best;
        cnt           = 0;
        allzero       = 1'b1;
        ripzero       = 1'b0;
        best          = '0;
        next_state    = state;
        next_sel      = sel;
        next_mode     = mode;
        next_main_ax  = main_ax;
        next_cax      = cax;
        next_abort    = start_abort_error_flag;
        next_cok      = circ_setup_ok;
        next_cax1h    = circ_ctrl_axis;
        next_rate_cnt = rate_cnt;
        next_main_tick = 1'b0;
        next_pulse    = '0;
        next_dir      = dir_neg;
        next_busy     = busy;
        next_decel    = decel;
        for (int i = 0; i < N; i++) begin
            next_rem[i] = rem[i];
        end
        case (state)
            MAIC_IDLE: begin
                if (do_start) begin
                    next_sel   = cmd_start ? axis_select_bits : sel;
                    next_mode  = operation_mode_field[0];
                    for (int i = N - 1; i >= 0; i--) begin
                        if (next_sel[i]) begin
                            next_mode = operation_mode_field[i];
                        end
                    end
                    next_state = MAIC_CHECK;
                end
            end
            MAIC_CHECK: begin
                next_cax = 2'd0;
                for (int i = N - 1; i >= 0; i--) begin
                    if (sel[i]) begin
                        next_cax = 2'(i);  // Earliest selected axis gives speed
                    end
                end
                for (int i = 0; i < N; i++) begin
                    if (sel[i]) begin
                        cnt = cnt + 1;
                        if (mag[i] != '0) begin
                            allzero = 1'b0;
                        end
                        if (interpolation_reference_amount[i] == '0) begin
                            ripzero = 1'b1;
                        end
                        if (mag[i] > best || cnt == 1) begin
                            best         = mag[i];
                            next_main_ax = 2'(i);
                        end
                        next_dir[i] = target_move_amount[i][W-1];
                        next_rem[i] = mag[i];
                    end
                end
                next_cax1h = '0;
                next_cok   = 1'b0;
                if (mode == `MAIC_MODE_CIRC_CW || mode == `MAIC_MODE_CIRC_CCW) begin
                    // Only X-Y, Y-Z, Z-U and X-U pairs are accepted
                    next_cok = (cnt == 2) && (sel == 4'h3 || sel == 4'h6 ||
                                              sel == 4'hc || sel == 4'h9);
                    next_cax1h = next_cok ? (4'h1 << next_cax) : 4'h0;
                    next_state = MAIC_DONE;  // Arc stepping lives outside this block
                    if (!next_cok) begin
                        next_abort = 1'b1;
                    end
                end else if ((mode == `MAIC_MODE_LIN1_INC || mode == `MAIC_MODE_LIN1_CONT)
                             && cnt < 2) begin
                    next_abort = 1'b1;
                    next_state = MAIC_DONE;
                end else if (mode == `MAIC_MODE_LIN2_INC && ripzero) begin
                    next_abort = 1'b1;
                    next_state = MAIC_DONE;
                end else if (allzero && mode != `MAIC_MODE_LIN2_CONT) begin
                    next_state = MAIC_DONE;
                end else begin
                    next_busy     = sel;
                    next_rate_cnt = `MAIC_RATE_DIV_RESET;
                    next_state    = MAIC_RUN;
                end
            end
            MAIC_RUN: begin
                // Main pulse rate from the control axis divider only
                if (rate_cnt >= high_speed_value[cax]) begin
                    next_rate_cnt  = `MAIC_RATE_DIV_RESET;
                    next_main_tick = 1'b1;
                end else begin
                    next_rate_cnt = rate_cnt + 16'h0001;
                end
                for (int i = 0; i < N; i++) begin
                    if (sel[i] && rem[i] != '0 &&
                        (i == int'(main_ax) ? main_tick : fstep[i])) begin
                        next_pulse[i] = 1'b1;
                        if (mode != `MAIC_MODE_LIN2_CONT) begin
                            next_rem[i] = rem[i] - 1'b1;
                        end
                    end
                    if (remote_main && mode == `MAIC_MODE_LIN2_INC && next_rem[i] == '0) begin
                        next_busy[i] = 1'b0;
                    end
                    // Constant rate only in multi-chip modes
                    next_decel[i] = sel[i] && !mode[1] &&
                        (slowdown_point_manual_select[main_ax] ||
                         high_speed_correction_manual_select[main_ax]) &&
                        rem[main_ax] < slowdown_point_value;
                end
                if (do_stop) begin
                    next_state = MAIC_DONE;
                end else if (mode != `MAIC_MODE_LIN2_CONT && !remote_main &&
                             next_rem[main_ax] == '0) begin
                    next_state = MAIC_DONE;
                end else if (remote_main && next_busy == '0) begin
                    next_state = MAIC_DONE;
                end
            end
            MAIC_DONE: begin
                next_busy  = '0;  // All axes drop together
                next_decel = '0;
                next_state = MAIC_IDLE;
            end
            default: begin
                next_state = MAIC_IDLE;
            end
        endcase
        // Shared status word, readable whatever the axis
        next_sts = 8'h00;
        next_sts[`MAIC_STS_BUSY_BIT]  = |next_busy;
        next_sts[`MAIC_STS_DONE_BIT]  = (state == MAIC_DONE);
        next_sts[`MAIC_STS_ABORT_BIT] = next_abort;
        next_sts[`MAIC_STS_DECEL_BIT] = |next_decel;
        next_sts[`MAIC_STS_CIRC_BIT]  = next_cok;
    end

    // Register every output so that all leave straight from flops
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            state                       <= MAIC_IDLE;
            sel                         <= '0;
            mode                        <= 8'h00;
            main_ax                     <= 2'd0;
            cax                         <= 2'd0;
            rate_cnt                    <= `MAIC_RATE_DIV_RESET;
            main_tick                   <= 1'b0;
            pulse_out                   <= '0;
            dir_neg                     <= '0;
            busy                        <= '0;
            decel                       <= '0;
            start_abort_error_flag      <= 1'b0;
            circ_setup_ok               <= 1'b0;
            circ_ctrl_axis              <= '0;
            shared_interpolation_status <= 8'h00;
            ctrl_axis                   <= 2'd0;
            for (int i = 0; i < N; i++) begin
                rem[i] <= '0;
            end
        end else begin
            state                       <= next_state;
            sel                         <= next_sel;
            mode                        <= next_mode;
            main_ax                     <= next_main_ax;
            cax                         <= next_cax;
            rate_cnt                    <= next_rate_cnt;
            main_tick                   <= next_main_tick;
            pulse_out                   <= next_pulse;
            dir_neg                     <= next_dir;
            busy                        <= next_busy;
            decel                       <= next_decel;
            start_abort_error_flag      <= next_abort;
            circ_setup_ok               <= next_cok;
            circ_ctrl_axis              <= next_cax1h;
            shared_interpolation_status <= next_sts;
            ctrl_axis                   <= next_cax;
            for (int i = 0; i < N; i++) begin
                rem[i] <= next_rem[i];
            end
        end
    end

    // Checks on the sequencer
    AST_ABORT_NO_PULSE: assert property (@(posedge core_clk) disable iff (!nrst)
        $rose(start_abort_error_flag) |-> pulse_out == '0 && busy == '0)
        else $error("Pulse during start abort");
    AST_BUSY_DROP: assert property (@(posedge core_clk) disable iff (!nrst)
        state == MAIC_DONE |=> busy == '0)
        else $error("Busy stayed after completion");
    AST_PULSE_ONLY_SEL: assert property (@(posedge core_clk) disable iff (!nrst)
        (pulse_out & ~sel) == '0)
        else $error("Pulse on unselected axis");
    AST_NO_DECEL_LIN2: assert property (@(posedge core_clk) disable iff (!nrst)
        (state == MAIC_RUN && mode[1]) |-> ##1 decel == '0)
        else $error("Deceleration in multi-chip mode");
    AST_STOP_ENDS: assert property (@(posedge core_clk) disable iff (!nrst)
        (state == MAIC_RUN && cmd_stop) |=> state == MAIC_DONE ##1 busy == '0)
        else $error("Stop did not end run");
    AST_MAIN_LARGEST: assert property (@(posedge core_clk) disable iff (!nrst)
        state == MAIC_RUN |-> mag[main_ax] >= mag[0] || !sel[0])
        else $error("Main axis not largest");
    AST_ZERO_DONE: assert property (@(posedge core_clk) disable iff (!nrst)
        (state == MAIC_CHECK && mode == `MAIC_MODE_LIN1_INC && (sel & (sel - 1'b1)) != '0
         && (mag[0] | mag[1] | mag[2] | mag[3]) == '0) |=> state == MAIC_DONE)
        else $error("All-zero move did not complete");
    AST_STS_BUSY: assert property (@(posedge core_clk) disable iff (!nrst)
        shared_interpolation_status[`MAIC_STS_BUSY_BIT] == (|busy))
        else $error("Shared status busy mismatch");
    COV_RUN_DONE: cover property (@(posedge core_clk) disable iff (!nrst)
        state == MAIC_RUN ##1 state == MAIC_DONE);
    COV_ABORT: cover property (@(posedge core_clk) disable iff (!nrst)
        $rose(start_abort_error_flag));
    COV_CIRC: cover property (@(posedge core_clk) disable iff (!nrst) $rose(circ_setup_ok));
endmodule

// file: bench/maic_far_side.sv
// Far-side model: motor drivers tallying steps, plus a cascaded chip's shared pins.
// Assumes pulse_out strobes last one core_clk cycle and pins are sampled on core_clk.
`timescale 1ns/1ps
module maic_far_side (
    input  wire logic       core_clk,  // System clock
    input  wire logic [3:0] pulse_out, // Command pulses
    input  wire logic [3:0] dir_neg,   // 1 = negative step
    input  wire logic [3:0] decel,     // Deceleration request
    output logic            start_ln,  // Shared start pin
    output logic            stop_ln    // Shared stop pin
);
    int   pos [4];
    logic saw_decel;

    initial begin
        start_ln = 1'b0;
        stop_ln = 1'b0;
        saw_decel = 1'b0;
        foreach (pos[i]) pos[i] = 0;
    end

    // Signed step tally per axis; a driver only sees strobes, so direction is taken per step
    always @(posedge core_clk) begin
        for (int i = 0; i < 4; i++) begin
            if (pulse_out[i]) pos[i] <= pos[i] + (dir_neg[i] ? -1 : 1);
        end
        if (|decel) saw_decel <= 1'b1;
    end

    // Called at a falling edge, clear of the tally updates
    task automatic clear();
        foreach (pos[i]) pos[i] = 0;
        saw_decel = 1'b0;
    endtask

    // Another chip starts the group: the level is held long enough to pass the pin sync
    task automatic pulse_start();
        @(negedge core_clk);
        start_ln = 1'b1;
        repeat (4) @(negedge core_clk);
        start_ln = 1'b0;
    endtask

    // Another chip halts the group, as an abnormal stop would spread
    task automatic pulse_stop();
        @(negedge core_clk);
        stop_ln = 1'b1;
        repeat (4) @(negedge core_clk);
        stop_ln = 1'b0;
    endtask
endmodule

// file: bench/maic_core_tb.sv
// Self-checking bench for the interpolation controller, one task per scenario.
// Assumes the far-side model file is compiled first; N=4, W=28.
`timescale 1ns/1ps
`include "maic_consts.svh"
module maic_core_tb;
    logic        core_clk, nrst, remote_main, command_write_area, command_is_stop;
    logic [7:0]  mode [4];
    logic [27:0] amt [4];
    logic [27:0] ref_amt [4];
    logic [27:0] slowdown_point_value;
    logic [3:0]  sp_man, hs_man, axis_select_bits;
    logic [15:0] high_speed_value [4];
    logic [3:0]  pulse_out, dir_neg, busy, decel, circ_ctrl_axis;
    logic        start_abort_error_flag, circ_setup_ok, start_ln, stop_ln;
    logic [7:0]  sts;
    logic [1:0]  ctrl_axis;
    int          num_errors = 0, checks = 0, cycles = 0;

    maic_core uut (.core_clk(core_clk), .nrst(nrst), .operation_mode_field(mode),
        .target_move_amount(amt), .interpolation_reference_amount(ref_amt),
        .slowdown_point_value(slowdown_point_value), .slowdown_point_manual_select(sp_man),
        .high_speed_correction_manual_select(hs_man), .high_speed_value(high_speed_value),
        .remote_main(remote_main), .command_write_area(command_write_area),
        .command_is_stop(command_is_stop), .axis_select_bits(axis_select_bits),
        .simultaneous_start_line(start_ln), .simultaneous_stop_line(stop_ln),
        .pulse_out(pulse_out), .dir_neg(dir_neg), .busy(busy), .decel(decel),
        .start_abort_error_flag(start_abort_error_flag), .circ_setup_ok(circ_setup_ok),
        .circ_ctrl_axis(circ_ctrl_axis), .shared_interpolation_status(sts),
        .ctrl_axis(ctrl_axis));
    maic_far_side far (.core_clk(core_clk), .pulse_out(pulse_out), .dir_neg(dir_neg),
        .decel(decel), .start_ln(start_ln), .stop_ln(stop_ln));

    // 100 MHz clock and a cycle ceiling well above the whole sequence
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            stop_test();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic do_reset();
        @(negedge core_clk);
        nrst = 1'b0;
        repeat (5) @(negedge core_clk);
        nrst = 1'b1;
    endtask
    // Same mode on every axis; only the selected axes take part
    task automatic prep(input logic [7:0] md, input int a0, a1, a2, a3);
        @(negedge core_clk);
        far.clear();
        foreach (mode[i]) mode[i] = md;
        amt[0] = 28'(a0);
        amt[1] = 28'(a1);
        amt[2] = 28'(a2);
        amt[3] = 28'(a3);
    endtask
    task automatic cmd(input logic stp, input logic [3:0] sel);
        @(negedge core_clk);
        command_write_area = 1'b1;
        command_is_stop = stp;
        axis_select_bits = sel;
        @(negedge core_clk);
        command_write_area = 1'b0;
    endtask
    // Done is a one-cycle bit, so it is looked at every cycle
    task automatic wait_done();
        int n;
        for (n = 0; n < 3000 && sts[`MAIC_STS_DONE_BIT] !== 1'b1; n++) @(negedge core_clk);
        chk(32'(n < 3000), 32'h1);
        repeat (2) @(negedge core_clk);
        chk(32'(busy), 32'h0);
    endtask
    task automatic chk_pos(input int e0, e1, e2, e3);
        chk(32'(far.pos[0]), 32'(e0));
        chk(32'(far.pos[1]), 32'(e1));
        chk(32'(far.pos[2]), 32'(e2));
        chk(32'(far.pos[3]), 32'(e3));
    endtask

    task automatic s_inc();
        prep(8'h61, 5, -10, 2, 0);
        cmd(1'b0, 4'h7);
        wait_done();
        chk_pos(5, -10, 2, 0);
        chk(32'(far.saw_decel), 32'h0);
        chk(32'(ctrl_axis), 32'h0);
        chk(32'(start_abort_error_flag), 32'h0);
    endtask
    // Manual slowdown point first, then auto point with manual correction
    task automatic s_decel();
        for (int k = 0; k < 2; k++) begin
            sp_man = k[0] ? 4'h0 : 4'hf; // Same on every axis
            hs_man = k[0] ? 4'hf : 4'h0;
            prep(8'h61, 3, 8, 0, 0);
            cmd(1'b0, 4'h3);
            wait_done();
            chk(32'(far.saw_decel), 32'h1);
            chk_pos(3, 8, 0, 0);
        end
        sp_man = 4'h0;
        hs_man = 4'h0;
    endtask
    task automatic s_zero();
        prep(8'h61, 0, 0, 0, 0);
        cmd(1'b0, 4'h3);
        wait_done();
        chk_pos(0, 0, 0, 0);
        chk(32'(start_abort_error_flag), 32'h0);
    endtask
    // Runs until stopped; the follower must track main within half a step
    // Stopped once by command and once by the shared stop pin
    task automatic s_cont();
        int d;
        for (int k = 0; k < 2; k++) begin
            prep(8'h62, 2, 4, 0, 0);
            cmd(1'b0, 4'h3);
            repeat (40) @(negedge core_clk);
            chk(32'(busy), 32'h3);
            if (k == 0) cmd(1'b1, 4'h3);
            else far.pulse_stop();
            wait_done();
            d = 2 * far.pos[0] - far.pos[1];
            chk(32'(far.pos[1] > 4 && d <= 1 && d >= -1), 32'h1);
        end
    endtask
    task automatic s_pin();
        prep(8'h61, 6, 3, 0, 0);
        far.pulse_start();
        wait_done();
        chk_pos(6, 3, 0, 0);
    endtask
    task automatic s_remote();
        remote_main = 1'b1;
        sp_man = 4'hf;
        prep(8'h63, 3, -6, 0, 0);
        cmd(1'b0, 4'h3);
        wait_done();
        chk_pos(3, -6, 0, 0);
        chk(32'(far.saw_decel), 32'h0);
        remote_main = 1'b0;
        sp_man = 4'h0;
    endtask
    // Every legal pair, with the earliest axis as the speed source
    task automatic s_circ();
        logic [3:0] pr [4] = '{4'h3, 4'h6, 4'hc, 4'h9};
        logic [1:0] cx [4] = '{2'h0, 2'h1, 2'h2, 2'h0};
        for (int k = 0; k < 4; k++) begin
            prep(k[0] ? 8'h65 : 8'h64, 10, 0, 0, 0);
            cmd(1'b0, pr[k]);
            repeat (2) @(negedge core_clk);
            chk(32'(circ_setup_ok), 32'h1);
            chk(32'(ctrl_axis), 32'(cx[k]));
            chk(32'(circ_ctrl_axis), 32'(4'h1 << cx[k]));
            cmd(1'b1, pr[k]);
            repeat (20) @(negedge core_clk);
        end
    endtask
    task automatic s_abort(input logic [7:0] md, input logic [3:0] sel);
        do_reset();
        prep(md, 4, 2, 0, 0);
        cmd(1'b0, sel);
        wait_done();
        chk_pos(0, 0, 0, 0);
        chk(32'(start_abort_error_flag), 32'h1);
        chk(32'(sts[`MAIC_STS_ABORT_BIT]), 32'h1);
    endtask

    initial begin
        nrst = 1'b0;
        remote_main = 1'b0;
        command_write_area = 1'b0;
        command_is_stop = 1'b0;
        axis_select_bits = 4'h0;
        slowdown_point_value = 28'h4;
        sp_man = 4'h0;
        hs_man = 4'h0;
        foreach (mode[i]) begin
            mode[i] = 8'h61;
            amt[i] = 28'h0;
            ref_amt[i] = 28'ha; // Main amount of the group
            high_speed_value[i] = 16'h2; // Same divider everywhere
        end
        do_reset();
        s_inc();
        s_decel();
        s_zero();
        s_cont();
        s_pin();
        s_remote();
        s_circ();
        s_abort(8'h61, 4'h1);
        s_abort(8'h60, 4'h2);
        s_abort(8'h64, 4'h5);
        ref_amt[1] = 28'h0;
        s_abort(8'h63, 4'h3);
        stop_test();
    end
endmodule
